/* hw/caf_defs.svh */
// Constants for the addressing and flow-control core
`ifndef CAF_DEFS_SVH
`define CAF_DEFS_SVH
`define CAF_PC_RST   15'h0000
`define CAF_SP_RST   8'h6F
`define CAF_TRAP_VEC 15'h00FF
`define CAF_REL_BIAS 15'h001F
// Opcode groups, upper nibble or upper five bits
`define CAF_G_LDB    4'h4
`define CAF_G_JMP    4'h5
`define CAF_G_JSR    4'h6
`define CAF_G_ACC    4'h9
`define CAF_G_CTL    4'hB
`define CAF_G_ALUI   5'h0E
`define CAF_G_ALUB   5'h0F
`define CAF_G_BSET   5'h10
`define CAF_G_BCLR   5'h11
`define CAF_G_XPTR   5'h14
`define CAF_G_LPTR   5'h15
`define CAF_G_ALUD   5'h18
// Control group, low nibble
`define CAF_C_FULL_ABSOLUTE_JUMP   4'h0
`define CAF_C_FULL_SUBROUTINE_CALL   4'h1
`define CAF_C_RET    4'h2
`define CAF_C_RETURN_THEN_SKIP  4'h3
`define CAF_C_INTERRUPT_RETURN   4'h4
`define CAF_C_TRAP   4'h5
`define CAF_C_VIS    4'h6
`define CAF_C_TABLE_READ_TO_ACC   4'h7
`define CAF_C_JID    4'h8
`define CAF_C_SOFT_PENDING_CLEAR   4'h9
`define CAF_C_PUSH   4'hA
`define CAF_C_POP    4'hB
`define CAF_C_IFEQ   4'hC
`define CAF_C_IFC    4'hD
// Accumulator group, low nibble
`define CAF_A_CLR    4'h0
`define CAF_A_INC    4'h1
`define CAF_A_DEC    4'h2
`define CAF_A_DADJ   4'h3
`define CAF_A_SC     4'h4
`define CAF_A_RC     4'h5
`define CAF_A_RRC    4'h6
`define CAF_A_RLC    4'h7
`define CAF_A_SWAP   4'h8
// Two-operand operations, low three bits
`define CAF_U_ADD    3'h0
`define CAF_U_ADC    3'h1
`define CAF_U_SUB    3'h2
`define CAF_U_SUBTRACT_CARRY_OP   3'h3
`define CAF_U_AND    3'h4
`define CAF_U_OR     3'h5
`define CAF_U_XOR    3'h6
`define CAF_U_LD     3'h7
// Pointer adjust modes, low two bits
`define CAF_P_INC    2'h1
`define CAF_P_DEC    2'h2
`endif

/* hw/caf_pkg.sv */
// Types shared by the addressing and flow-control core
package caf_pkg;
    typedef enum logic [3:0] {
        S_NXT = 4'b0000,
        S_FET = 4'b0001,
        S_OP1 = 4'b0010,
        S_OP2 = 4'b0011,
        S_EXE = 4'b0100,
        S_MEM = 4'b0101,
        S_WB  = 4'b0110,
        S_PSH = 4'b0111,
        S_POP = 4'b1000,
        S_PRD = 4'b1001
    } caf_state_e;
    typedef struct packed {
        logic        rd;
        logic [14:0] addr;
    } caf_pm_req_s;
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } caf_dm_req_s;
endpackage : caf_pkg

/* hw/caf_core.sv */
// Fetch, decode and execute core for operand and flow-control modes
`timescale 1ns/100ps
`include "caf_defs.svh"
// Notes on behaviour
// (RULE1) Immediate operands come from program bytes right after the opcode.
// (RULE2) Short load of B puts 4-bit value low, clears high nibble.
// (RULE3) Table read addresses program memory with A as low byte.
// (RULE4) Program counter is 15 bits; top bit of upper byte unused.
// (RULE5) Relative jump offset from six opcode bits, range -31 to +32.
// (RULE6) Page jump replaces low 12 bits, keeps top three bits.
// (RULE7) Full jump loads all 15 bits from the instruction.
// (RULE8) Indirect jump fetches new low byte via A, upper unchanged.
// (RULE9) Vector select loads a two-byte vector into the counter.
// (RULE10) After a false test the next instruction runs with no effect.
// (RULE11) Calls push the counter first; returns pop it back.
// (RULE12) Add, subtract, carry forms, inc, dec, decimal adjust, clear, carry.
// (RULE13) AND, OR, XOR on A; XOR with all ones complements.
// (RULE14) Rotate A through carry both ways; swap nibbles.
// (RULE15) Set or clear any memory bit; clear soft trap pending flag.
// (RULE16) Load and exchange read bytes into A; only exchange writes A back; mode picks the source.
// (RULE17) Pointer-indirect uses B or X as the data address.
// (RULE18) Post-increment or decrement adjusts pointer after the access.
// (RULE19) Counter advances past every byte; table read keeps that value.
module caf_core (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [14:0]  vec_addr_i,
    input  wire logic [7:0]   pm_data_i,
    input  wire logic [7:0]   dm_rdata_i,
    output caf_pkg::caf_pm_req_s pm_o,
    output caf_pkg::caf_dm_req_s dm_o,
    output logic      [14:0]  pc_o,
    output logic      [7:0]   acc_o,
    output logic      [7:0]   ptr_b_o,
    output logic      [7:0]   ptr_x_o,
    output logic      [7:0]   sp_o,
    output logic              carry_o,
    output logic              half_carry_o,
    output logic              skip_o,
    output logic              soft_pend_o
);
    caf_pkg::caf_state_e  state_reg;
    caf_pkg::caf_pm_req_s pm_reg;
    caf_pkg::caf_dm_req_s dm_reg;
    logic        step_reg;
    logic [14:0] pc_reg;
    logic [14:0] opc_pc_reg;
    logic [7:0]  opc_reg;
    logic [7:0]  op1_reg;
    logic [7:0]  op2_reg;
    logic [7:0]  hi_reg;
    logic [7:0]  acc_reg;
    logic [7:0]  b_reg;
    logic [7:0]  x_reg;
    logic [7:0]  sp_reg;
    logic        c_reg;
    logic        hc_reg;
    logic        skip_reg;
    logic        pend_reg;

    function automatic logic [1:0] n_ops(input logic [7:0] o);
        case (o[7:4])
            `CAF_G_JMP, `CAF_G_JSR: n_ops = 2'h1;
            `CAF_G_CTL: begin
                if (o[3:0] == `CAF_C_FULL_ABSOLUTE_JUMP || o[3:0] == `CAF_C_FULL_SUBROUTINE_CALL)
                    n_ops = 2'h2;
                else
                    n_ops = {1'b0, o[3:0] == `CAF_C_IFEQ};
            end
            default: begin
                n_ops = {1'b0, o[7:3] == `CAF_G_ALUI
                               || o[7:3] == `CAF_G_ALUD};
            end
        endcase
    endfunction : n_ops

    // Result is {hc, c, value}; only carry forms touch the flags
    function automatic logic [9:0] alu(input logic [2:0] op,
                                       input logic [7:0] a,
                                       input logic [7:0] m,
                                       input logic       c,
                                       input logic       hc);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] mm;
        logic       sb;
        logic       ci;
        sb = op == `CAF_U_SUB || op == `CAF_U_SUBTRACT_CARRY_OP;
        mm = sb ? ~m : m;
        ci = (op == `CAF_U_ADC || op == `CAF_U_SUBTRACT_CARRY_OP) ? c : sb;
        s  = {1'b0, a} + {1'b0, mm} + {8'h00, ci};
        h  = {1'b0, a[3:0]} + {1'b0, mm[3:0]} + {4'h0, ci};
        case (op)
            `CAF_U_ADC, `CAF_U_SUBTRACT_CARRY_OP: alu = {h[4], s[8], s[7:0]};
            `CAF_U_ADD, `CAF_U_SUB: alu = {hc, c, s[7:0]};
            `CAF_U_AND: alu = {hc, c, a & m};                   // RULE13
            `CAF_U_OR:  alu = {hc, c, a | m};                   // RULE13
            `CAF_U_XOR: alu = {hc, c, a ^ m};                   // RULE13
            default:    alu = {hc, c, m};
        endcase
    endfunction : alu

    wire in_nxt = state_reg == caf_pkg::S_NXT;
    wire in_fet = state_reg == caf_pkg::S_FET;
    wire in_op1 = state_reg == caf_pkg::S_OP1;
    wire in_exe = state_reg == caf_pkg::S_EXE;
    wire in_mem = state_reg == caf_pkg::S_MEM;
    wire in_wb  = state_reg == caf_pkg::S_WB;
    wire in_psh = state_reg == caf_pkg::S_PSH;
    wire in_pop = state_reg == caf_pkg::S_POP;
    wire in_prd = state_reg == caf_pkg::S_PRD;
    wire run    = in_exe && !skip_reg;
    wire is_rel  = opc_reg[7:6] == 2'h0;
    wire is_ldb  = opc_reg[7:4] == `CAF_G_LDB;
    wire is_jmp  = opc_reg[7:4] == `CAF_G_JMP;
    wire is_jsr  = opc_reg[7:4] == `CAF_G_JSR;
    wire is_acc  = opc_reg[7:4] == `CAF_G_ACC;
    wire is_ctl  = opc_reg[7:4] == `CAF_G_CTL;
    wire is_alui = opc_reg[7:3] == `CAF_G_ALUI;
    wire is_alub = opc_reg[7:3] == `CAF_G_ALUB;
    wire is_alud = opc_reg[7:3] == `CAF_G_ALUD;
    wire is_bset = opc_reg[7:3] == `CAF_G_BSET;
    wire is_bclr = opc_reg[7:3] == `CAF_G_BCLR;
    wire is_xptr = opc_reg[7:3] == `CAF_G_XPTR;
    wire is_lptr = opc_reg[7:3] == `CAF_G_LPTR;
    wire [3:0] ctl = is_ctl ? opc_reg[3:0] : 4'hF;
    wire is_ptr  = is_xptr || is_lptr;
    wire is_mem  = is_alub || is_alud || is_bset || is_bclr || is_ptr;
    wire is_call = is_jsr || ctl == `CAF_C_FULL_SUBROUTINE_CALL || ctl == `CAF_C_TRAP;
    wire is_ret  = ctl == `CAF_C_RET || ctl == `CAF_C_RETURN_THEN_SKIP
                   || ctl == `CAF_C_INTERRUPT_RETURN;
    wire [7:0] mem_addr = is_alud ? op1_reg                      // RULE17
                        : (is_ptr && opc_reg[2]) ? x_reg : b_reg;
    wire [7:0] bit_mask = 8'h01 << opc_reg[2:0];
    wire [7:0] opnd     = in_mem ? dm_rdata_i : op1_reg;
    wire [9:0] alu_r    = alu(opc_reg[2:0], acc_reg, opnd, c_reg, hc_reg);
    wire [14:0] call_tgt = is_jsr ? {pc_reg[14:12], opc_reg[3:0], op1_reg}
                         : ctl == `CAF_C_FULL_SUBROUTINE_CALL ? {op1_reg[6:0], op2_reg}
                         : `CAF_TRAP_VEC;
    // Opcode or operand address issued this cycle, so the counter moves on
    wire pm_step = in_nxt || (in_fet && n_ops(pm_data_i) != 2'h0)
                   || (in_op1 && n_ops(opc_reg) == 2'h2);

    assign pm_o         = pm_reg;
    assign dm_o         = dm_reg;
    assign pc_o         = pc_reg;
    assign acc_o        = acc_reg;
    assign ptr_b_o      = b_reg;
    assign ptr_x_o      = x_reg;
    assign sp_o         = sp_reg;
    assign carry_o      = c_reg;
    assign half_carry_o = hc_reg;
    assign skip_o       = skip_reg;
    assign soft_pend_o  = pend_reg;

    // Sequencer and memory requests
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg  <= caf_pkg::S_NXT;
            step_reg   <= 1'b0;
            pm_reg     <= '0;
            dm_reg     <= '0;
            opc_reg    <= 8'h00;
            opc_pc_reg <= `CAF_PC_RST;
            op1_reg    <= 8'h00;
            op2_reg    <= 8'h00;
            hi_reg     <= 8'h00;
        end else begin
            case (state_reg)
                caf_pkg::S_NXT: begin
                    pm_reg    <= '{rd: 1'b1, addr: pc_reg};
                    state_reg <= caf_pkg::S_FET;
                end
                caf_pkg::S_FET: begin
                    opc_reg    <= pm_data_i;
                    opc_pc_reg <= pm_reg.addr;
                    if (n_ops(pm_data_i) != 2'h0) begin
                        pm_reg.addr <= pc_reg;                  // RULE1
                        state_reg   <= caf_pkg::S_OP1;
                    end else begin
                        pm_reg.rd <= 1'b0;
                        state_reg <= caf_pkg::S_EXE;
                    end
                end
                caf_pkg::S_OP1: begin
                    op1_reg <= pm_data_i;
                    if (n_ops(opc_reg) == 2'h2) begin
                        pm_reg.addr <= pc_reg;
                        state_reg   <= caf_pkg::S_OP2;
                    end else begin
                        pm_reg.rd <= 1'b0;
                        state_reg <= caf_pkg::S_EXE;
                    end
                end
                caf_pkg::S_OP2: begin
                    op2_reg   <= pm_data_i;
                    pm_reg.rd <= 1'b0;
                    state_reg <= caf_pkg::S_EXE;
                end
                caf_pkg::S_EXE: begin
                    step_reg  <= 1'b0;
                    state_reg <= caf_pkg::S_NXT;
                    if (skip_reg) begin
                        state_reg <= caf_pkg::S_NXT;            // RULE10
                    end else if (is_mem) begin
                        dm_reg    <= '{1'b1, 1'b0, mem_addr, 8'h00};
                        state_reg <= caf_pkg::S_MEM;
                    end else if (is_call || ctl == `CAF_C_PUSH) begin
                        // Low byte first, so the upper byte ends on top
                        dm_reg    <= '{1'b0, 1'b1, sp_reg,
                                       is_call ? pc_reg[7:0] : acc_reg};
                        step_reg  <= !is_call;
                        state_reg <= caf_pkg::S_PSH;            // RULE11
                    end else if (is_ret || ctl == `CAF_C_POP) begin
                        dm_reg    <= '{1'b1, 1'b0, sp_reg + 8'h01, 8'h00};
                        step_reg  <= !is_ret;
                        state_reg <= caf_pkg::S_POP;            // RULE11
                    end else if (ctl == `CAF_C_TABLE_READ_TO_ACC || ctl == `CAF_C_JID) begin
                        pm_reg    <= '{1'b1, {pc_reg[14:8], acc_reg}};
                        state_reg <= caf_pkg::S_PRD;            // RULE3
                    end else if (ctl == `CAF_C_VIS) begin
                        pm_reg    <= '{1'b1, vec_addr_i};
                        state_reg <= caf_pkg::S_PRD;            // RULE9
                    end
                end
                caf_pkg::S_MEM: begin
                    dm_reg.rd <= 1'b0;
                    state_reg <= caf_pkg::S_WB;
                    if (is_xptr) begin
                        dm_reg.wr    <= 1'b1;                   // RULE16
                        dm_reg.wdata <= acc_reg;
                    end else if (is_bset || is_bclr) begin
                        dm_reg.wr    <= 1'b1;                   // RULE15
                        dm_reg.wdata <= is_bset ? dm_rdata_i | bit_mask
                                                : dm_rdata_i & ~bit_mask;
                    end
                end
                caf_pkg::S_WB: begin
                    dm_reg.wr <= 1'b0;
                    state_reg <= caf_pkg::S_NXT;
                end
                caf_pkg::S_PSH: begin
                    if (!step_reg) begin
                        dm_reg.addr  <= sp_reg;
                        dm_reg.wdata <= {1'b0, pc_reg[14:8]};
                        step_reg     <= 1'b1;
                    end else begin
                        dm_reg.wr <= 1'b0;
                        state_reg <= caf_pkg::S_NXT;
                    end
                end
                caf_pkg::S_POP: begin
                    if (!step_reg) begin
                        hi_reg      <= dm_rdata_i;
                        dm_reg.addr <= sp_reg + 8'h01;
                        step_reg    <= 1'b1;
                    end else begin
                        dm_reg.rd <= 1'b0;
                        state_reg <= caf_pkg::S_NXT;
                    end
                end
                caf_pkg::S_PRD: begin
                    if (ctl == `CAF_C_VIS && !step_reg) begin
                        hi_reg      <= pm_data_i;
                        pm_reg.addr <= pm_reg.addr + 15'h0001;  // RULE9
                        step_reg    <= 1'b1;
                    end else begin
                        pm_reg.rd <= 1'b0;
                        state_reg <= caf_pkg::S_NXT;
                    end
                end
                default: state_reg <= caf_pkg::S_NXT;
            endcase
        end
    end

    // Program counter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pc_reg <= `CAF_PC_RST;
        end else if (pm_step) begin
            pc_reg <= pc_reg + 15'h0001;                        // RULE19
        end else if (run && is_rel) begin
            pc_reg <= opc_pc_reg + {9'h000, opc_reg[5:0]}
                      - `CAF_REL_BIAS;                          // RULE5
        end else if (run && is_jmp) begin
            pc_reg[11:0] <= {opc_reg[3:0], op1_reg};            // RULE6
        end else if (run && ctl == `CAF_C_FULL_ABSOLUTE_JUMP) begin
            pc_reg <= {op1_reg[6:0], op2_reg};                  // RULE7
        end else if (in_psh && step_reg && is_call) begin
            pc_reg <= call_tgt;                                 // RULE11
        end else if (in_pop && step_reg && is_ret) begin
            pc_reg <= {hi_reg[6:0], dm_rdata_i};                // RULE4
        end else if (in_prd && ctl == `CAF_C_JID) begin
            pc_reg[7:0] <= pm_data_i;                           // RULE8
        end else if (in_prd && ctl == `CAF_C_VIS && step_reg) begin
            pc_reg <= {hi_reg[6:0], pm_data_i};                 // RULE9
        end
    end

    // Accumulator and carry flags
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_reg <= 8'h00;
            c_reg   <= 1'b0;
            hc_reg  <= 1'b0;
        end else if ((run && is_alui) || (in_mem && (is_alub || is_alud))) begin
            {hc_reg, c_reg, acc_reg} <= alu_r;                  // RULE12
        end else if (in_mem && is_ptr) begin
            acc_reg <= dm_rdata_i;                              // RULE16
        end else if (in_pop && step_reg && !is_ret) begin
            acc_reg <= dm_rdata_i;
        end else if (in_prd && ctl == `CAF_C_TABLE_READ_TO_ACC) begin
            acc_reg <= pm_data_i;                               // RULE3
        end else if (run && is_acc) begin
            case (opc_reg[3:0])
                `CAF_A_CLR: acc_reg <= 8'h00;                   // RULE12
                `CAF_A_INC: acc_reg <= acc_reg + 8'h01;
                `CAF_A_DEC: acc_reg <= acc_reg - 8'h01;
                `CAF_A_DADJ: begin
                    // Corrects after add with pre-biased operand
                    acc_reg <= acc_reg - (c_reg ? 8'h00 : 8'h60)
                               - (hc_reg ? 8'h00 : 8'h06);
                end
                `CAF_A_SC: c_reg <= 1'b1;
                `CAF_A_RC: c_reg <= 1'b0;
                `CAF_A_RRC: begin
                    {acc_reg, c_reg} <= {c_reg, acc_reg};       // RULE14
                end
                `CAF_A_RLC: begin
                    {c_reg, acc_reg} <= {acc_reg, c_reg};       // RULE14
                end
                `CAF_A_SWAP: acc_reg <= {acc_reg[3:0], acc_reg[7:4]};
                default: acc_reg <= acc_reg;
            endcase
        end
    end

    // Pointers and stack pointer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            b_reg  <= 8'h00;
            x_reg  <= 8'h00;
            sp_reg <= `CAF_SP_RST;
        end else begin
            if (run && is_ldb)
                b_reg <= {4'h0, opc_reg[3:0]};                  // RULE2
            // Adjust waits for the write-back so exchanges hit the old address
            if (in_wb && is_ptr && opc_reg[1:0] == `CAF_P_INC) begin
                if (opc_reg[2])
                    x_reg <= x_reg + 8'h01;                     // RULE18
                else
                    b_reg <= b_reg + 8'h01;                     // RULE18
            end
            if (in_wb && is_ptr && opc_reg[1:0] == `CAF_P_DEC) begin
                if (opc_reg[2])
                    x_reg <= x_reg - 8'h01;                     // RULE18
                else
                    b_reg <= b_reg - 8'h01;                     // RULE18
            end
            if ((run && (is_call || ctl == `CAF_C_PUSH))
                || (in_psh && !step_reg))
                sp_reg <= sp_reg - 8'h01;                       // RULE11
            if ((run && (is_ret || ctl == `CAF_C_POP))
                || (in_pop && !step_reg))
                sp_reg <= sp_reg + 8'h01;                       // RULE11
        end
    end

    // Skip and software trap pending
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            skip_reg <= 1'b0;
            pend_reg <= 1'b0;
        end else begin
            if (in_exe && skip_reg)
                skip_reg <= 1'b0;                               // RULE10
            else if (run && ctl == `CAF_C_IFEQ)
                skip_reg <= acc_reg != op1_reg;
            else if (run && ctl == `CAF_C_IFC)
                skip_reg <= !c_reg;
            else if (in_pop && step_reg && ctl == `CAF_C_RETURN_THEN_SKIP)
                skip_reg <= 1'b1;
            if (run && ctl == `CAF_C_TRAP)
                pend_reg <= 1'b1;
            else if (run && ctl == `CAF_C_SOFT_PENDING_CLEAR)
                pend_reg <= 1'b0;                               // RULE15
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_imm;
        in_op1 |-> pm_o.rd && pm_o.addr == opc_pc_reg + 15'h0001;
    endproperty
    a_imm: assert property (p_imm) // RULE1
        else $error("operand not read after opcode");
    property p_ldb;
        run && is_ldb |=> b_reg == {4'h0, $past(opc_reg[3:0])};
    endproperty
    a_ldb: assert property (p_ldb) // RULE2
        else $error("short load of B wrong");
    property p_table_read_to_acc;
        in_prd && ctl == `CAF_C_TABLE_READ_TO_ACC
            |-> pm_o.addr == {pc_reg[14:8], acc_reg}
            ##1 acc_reg == $past(pm_data_i) && $stable(pc_reg);
    endproperty
    a_table_read_to_acc: assert property (p_table_read_to_acc) // RULE3
        else $error("table read wrong");
    property p_rel;
        run && is_rel |=> pc_reg == $past(opc_pc_reg)
            + {9'h000, $past(opc_reg[5:0])} - `CAF_REL_BIAS;
    endproperty
    a_rel: assert property (p_rel) // RULE5
        else $error("relative jump target wrong");
    property p_page;
        run && is_jmp |=> pc_reg[14:12] == $past(pc_reg[14:12])
            && pc_reg[11:0] == {$past(opc_reg[3:0]), $past(op1_reg)};
    endproperty
    a_page: assert property (p_page) // RULE6
        else $error("page jump target wrong");
    property p_full;
        run && ctl == `CAF_C_FULL_ABSOLUTE_JUMP
            |=> pc_reg == {$past(op1_reg[6:0]), $past(op2_reg)};
    endproperty
    a_full: assert property (p_full) // RULE7
        else $error("full jump target wrong");
    property p_jid;
        in_prd && ctl == `CAF_C_JID |=> pc_reg
            == {$past(pc_reg[14:8]), $past(pm_data_i)};
    endproperty
    a_jid: assert property (p_jid) // RULE8
        else $error("indirect jump wrong");
    property p_skip;
        in_exe && skip_reg |=> in_nxt && !skip_reg && $stable(acc_reg)
            && $stable(b_reg) && $stable(sp_reg) && !dm_o.wr;
    endproperty
    a_skip: assert property (p_skip) // RULE10
        else $error("skipped instruction had effect");
    property p_call;
        run && is_jsr |=> dm_o.wr && dm_o.wdata == $past(pc_reg[7:0])
            ##1 dm_o.wr && dm_o.addr == $past(sp_reg, 2) - 8'h01;
    endproperty
    a_call: assert property (p_call) // RULE11
        else $error("call push wrong");
    property p_pinc;
        in_wb && is_ptr && !opc_reg[2] && opc_reg[1:0] == `CAF_P_INC
            |=> b_reg == $past(b_reg) + 8'h01;
    endproperty
    a_pinc: assert property (p_pinc) // RULE18
        else $error("post increment of B wrong");
endmodule : caf_core

/* dv/caf_mem_model.sv */
// Program and data memory seen by the core
`timescale 1ns/100ps
module caf_mem_model (
    input  wire logic                 clk_i,
    input  wire caf_pkg::caf_pm_req_s pm_i,
    input  wire caf_pkg::caf_dm_req_s dm_i,
    output logic [7:0]                pm_data_o,
    output logic [7:0]                dm_rdata_o
);
    logic [7:0] pm [0:32767];
    logic [7:0] dm [0:255];
    logic [7:0] pm_last = 8'h00;
    logic [7:0] dm_last = 8'h00;
    // Idle bus shows inverted last byte so stale data never passes
    assign pm_data_o  = pm_i.rd ? pm[pm_i.addr] : ~pm_last;
    assign dm_rdata_o = dm_i.rd ? dm[dm_i.addr] : ~dm_last;
    always @(posedge clk_i) begin
        if (pm_i.rd) pm_last <= pm[pm_i.addr];
        if (dm_i.rd) dm_last <= dm[dm_i.addr];
        if (dm_i.wr) dm[dm_i.addr] <= dm_i.wdata;
    end
endmodule : caf_mem_model

/* dv/test_cpu_addressing_and_flow_control.sv */
// Program-driven test of the addressing and flow-control core
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin n_fail++; \
    $display("wrong value %s exp %h seen %h", n, e, s); end end
module test_cpu_addressing_and_flow_control;
    logic clk_i = 1'b0, rst_n_i = 1'b0;
    logic [14:0] vec_addr_i = 15'h0000;
    logic [7:0]  pm_data, dm_rdata, acc_o, acc_seen = 8'h00, last_v = 8'h00;
    logic [7:0]  ptr_b_o, ptr_x_o, sp_o, e_v, r1, a3, d, t, u, v, k;
    logic [14:0] pc_o;
    logic        carry_o, half_carry_o, skip_o, soft_pend_o;
    logic [8:0]  s9;
    logic [4:0]  h5;
    logic [2:0]  bb;
    caf_pkg::caf_pm_req_s pm_o;
    caf_pkg::caf_dm_req_s dm_o;
    logic [7:0] exp_q [$];
    int n_fail = 0, cmp_count = 0, cycles = 0;
    logic [31:0] r;
    always #25 clk_i = ~clk_i;
    caf_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .vec_addr_i(vec_addr_i),
        .pm_data_i(pm_data), .dm_rdata_i(dm_rdata), .pm_o(pm_o), .dm_o(dm_o),
        .pc_o(pc_o), .acc_o(acc_o), .ptr_b_o(ptr_b_o), .ptr_x_o(ptr_x_o),
        .sp_o(sp_o), .carry_o(carry_o), .half_carry_o(half_carry_o),
        .skip_o(skip_o), .soft_pend_o(soft_pend_o));
    caf_mem_model mem (.clk_i(clk_i), .pm_i(pm_o), .dm_i(dm_o),
        .pm_data_o(pm_data), .dm_rdata_o(dm_rdata));
    task automatic seg(input logic [14:0] a, input logic [7:0] b [$]);
        foreach (b[i]) mem.pm[a + 15'(i)] = b[i];
    endtask : seg
    // Equal neighbours make no visible change, so they are not noted
    task automatic note(input logic [7:0] v);
        if (v !== last_v) exp_q.push_back(v);
        last_v = v;
    endtask : note
    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    always @(negedge clk_i) begin
        vec_addr_i <= 15'($urandom);
        if (acc_o !== acc_seen) begin
            e_v = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
            `CHK("acc", e_v, acc_o)
        end
        acc_seen = acc_o;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(32'hcabc654e));
        r  = $urandom;
        r1 = {r[3:0], ~r[3:0]};
        a3 = ~{r1[3:0], r1[7:4]};
        d  = {1'b1, r[14:8]};
        t  = {5'b01100, r[18:16]};
        k  = r[31:24];
        bb = r[22:20];
        // Set carry, then rotate left: carry enters bit 0
        u  = t + 8'h02;
        v  = {u[6:0], 1'b1};
        s9 = {1'b0, v} + {1'b0, k} + {8'h00, u[7]};
        h5 = {1'b0, v[3:0]} + {1'b0, k[3:0]} + {4'h0, u[7]};
        seg(15'h0000, '{8'h47, 8'h70, r1, 8'h98, 8'h76, 8'hFF, 8'hA1,
            8'h54, 8'h00});
        seg(15'h0400, '{8'hB0, 8'h10, 8'h20});
        seg(15'h1020, '{8'h3F});
        seg(15'h1040, '{8'hB7, 8'h60, 8'h50, 8'hB8});
        seg(15'h1050, '{8'h91, 8'hB2});
        // False compare must turn the first increment into a no-op
        // Trap comes last, so its push is what the stack holds at the end
        seg(15'h1070, '{8'hBC, 8'h00, 8'h91, 8'h91, 8'h94, 8'h97, 8'h71, k,
            8'hA5, {5'b10000, bb}, 8'hB5});
        mem.pm[15'h00FF] = 8'h1F;
        mem.pm[{7'h10, d}] = t;
        mem.pm[{7'h10, t + 8'h01}] = 8'h70;
        mem.dm[7] = d;
        mem.dm[0] = r[7:0];
        mem.dm[8] = 8'h00;
        note(r1);
        note({r1[3:0], r1[7:4]});
        note(a3);
        note(d);
        note(t);
        note(t + 8'h01);
        note(t + 8'h02);
        note(v);
        note(s9[7:0]);
        note(r[7:0]);
        repeat (16) @(posedge clk_i);
        @(negedge clk_i) rst_n_i = 1'b1;
        repeat (300) @(negedge clk_i);
        `CHK("ptr b", 8'h08, ptr_b_o)
        `CHK("exchanged byte", a3, mem.dm[7])
        `CHK("stacked low", 8'h7B, mem.dm[8'h6F])
        `CHK("stacked high", 8'h10, mem.dm[8'h6E])
        `CHK("sp", 8'h6D, sp_o)
        `CHK("notes left", 0, exp_q.size())
        `CHK("carry", s9[8], carry_o)
        `CHK("half carry", h5[4], half_carry_o)
        `CHK("ptr x", 8'h01, ptr_x_o)
        `CHK("exchanged via x", s9[7:0], mem.dm[0])
        `CHK("bit set", 8'h01 << bb, mem.dm[8])
        `CHK("pending", 1'b1, soft_pend_o)
        `CHK("skip", 1'b0, skip_o)
        `CHK("pc", 1'b1, pc_o inside {15'h00FF, 15'h0100})
        complete_run();
    end
endmodule : test_cpu_addressing_and_flow_control
